//--- rtl/nco_pkg.sv
/*
 * Constants, register map and loader states of the phase-accumulator
 * oscillator, together with the list of its behaviours.
 * Assumes a single 10 MHz register clock and a byte-wide register port.
 */
// Function
// - 20-bit accumulator as three byte registers
// - Each selected-clock rising edge adds buffered increment
// - 20-bit increment in low, high, upper bytes
// - Low write loads buffer on second edge
// - Increment double-buffered, buffer hidden from software
// - Disabled: buffer loads right after the write
// - Fixed-duty mode toggles output on each overflow
// - Control bit 7 enable, bit 0 mode
// - Pulse mode: active from edge after overflow
// - Width field bits 7-5 gives two-power periods
// - Width field ignored in fixed-duty mode
// - Width beyond overflow period keeps output active
// - Polarity bit 4 inverts final output
// - Polarity change with interrupts on sets flag
// - Read-only bit 5 shows final output
// - Overflow sets flag; request needs four enables
// - Reset clears all; increment low bit0 one
// - Clock select bits 1-0 choose input clock
// - Keep fast oscillator alive when enabled, selected
// - Adder carry is the raw overflow event
package nco_pkg;

    // --------------------------------------------------------------
    // Widths
    // --------------------------------------------------------------
    localparam int ACC_W  = 20;             // Accumulator width
    localparam int ADDR_W = 4;              // Register address width
    localparam int DATA_W = 8;              // Register data width
    localparam int PWC_W  = 8;              // Pulse counter width

    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [3:0] OFS_CON  = 4'h0; // Oscillator control
    localparam logic [3:0] OFS_CLK  = 4'h1; // Input clock control
    localparam logic [3:0] OFS_ACCL = 4'h2; // Accumulator low byte
    localparam logic [3:0] OFS_ACCH = 4'h3; // Accumulator high byte
    localparam logic [3:0] OFS_ACCU = 4'h4; // Accumulator upper byte
    localparam logic [3:0] OFS_INCL = 4'h5; // Increment low byte
    localparam logic [3:0] OFS_INCH = 4'h6; // Increment high byte
    localparam logic [3:0] OFS_INCU = 4'h7; // Increment upper byte
    localparam logic [3:0] OFS_IRQ  = 4'h8; // Flag and enables

    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int CON_EN   = 7;            // osc_enable
    localparam int CON_OUT  = 5;            // output_state_bit
    localparam int CON_POL  = 4;            // output_polarity
    localparam int CON_PFM  = 0;            // pulse_mode_select
    localparam int CLK_PWS  = 5;            // pulse_width_select lsb
    localparam int CLK_CKS  = 0;            // input_clock_select lsb
    localparam int IRQ_FLAG = 0;            // overflow_irq_flag
    localparam int IRQ_IE   = 1;            // overflow_irq_enable
    localparam int IRQ_PE   = 2;            // peripheral_irq_enable
    localparam int IRQ_GE   = 3;            // global_irq_enable

    // --------------------------------------------------------------
    // Clock source codes
    // --------------------------------------------------------------
    localparam logic [1:0] CKS_FAST  = 2'h0; // internal_fast_oscillator
    localparam logic [1:0] CKS_SYS   = 2'h1; // System clock input
    localparam logic [1:0] CKS_CELL  = 2'h2; // logic_cell_one_output
    localparam logic [1:0] CKS_RSVD  = 2'h3; // Reserved, no edges

    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [19:0] INC_RST = 20'h00001; // Increment at reset
    localparam logic [19:0] ACC_RST = 20'h00000; // Accumulator at reset

    // --------------------------------------------------------------
    // Increment loader states
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        LD_IDLE  = 2'h0,                    // Nothing pending
        LD_ARMED = 2'h1,                    // Low byte written
        LD_SEEN1 = 2'h3                     // First edge seen
    } nco_load_e;

endpackage

//--- rtl/nco_top.sv
/*
 * Phase-accumulator oscillator with byte register port, double-buffered
 * increment, fixed-duty and pulse output modes and overflow flag.
 * Assumes all inputs synchronous to REF_CLK; the selected source clock
 * is sampled and its rising edges become one-cycle enables.
 */
// The address-and-strobe port and the register addresses were left to the implementer.
`timescale 1ns/1ps

module nco_top
    import nco_pkg::*;
(
    input  wire logic              REF_CLK,     // 10 MHz register clock
    input  wire logic              RESETN,      // Async reset, active low
    input  wire logic [ADDR_W-1:0] ADDR,        // Register address
    input  wire logic [DATA_W-1:0] WDATA,       // Write data
    input  wire logic              WR,          // Write strobe
    input  wire logic              RD,          // Read strobe
    output logic      [DATA_W-1:0] RDATA,       // Read data, next cycle
    input  wire logic              FAST_OSC,    // Fast oscillator level
    input  wire logic              SYS_CLK_SRC, // System clock level
    input  wire logic              CELL_OUT,    // Logic cell one level
    output logic                   NCO_OUT,     // Final output
    output logic                   IRQ,         // Gated interrupt request
    output logic                   KEEP_FAST    // Fast osc keep-alive
);

    // --------------------------------------------------------------
    // State record
    // --------------------------------------------------------------
    typedef struct packed {
        logic              en;       // osc_enable
        logic              pol;      // output_polarity
        logic              pfm;      // pulse_mode_select
        logic [2:0]        pws;      // pulse_width_select
        logic [1:0]        cks;      // input_clock_select
        logic [ACC_W-1:0]  acc;      // phase_accumulator
        logic [ACC_W-1:0]  inc;      // phase_increment, visible
        logic [ACC_W-1:0]  shadow;   // increment_shadow, hidden
        nco_load_e         ld;       // Loader state
        logic              src_prev; // Previous source level
        logic              pf_pend;  // Overflow awaiting next edge
        logic              raw;      // Output before polarity
        logic [PWC_W-1:0]  pw_cnt;   // Remaining active periods
        logic              flag;     // overflow_irq_flag
        logic              ie;       // overflow_irq_enable
        logic              pe;       // peripheral_irq_enable
        logic              ge;       // global_irq_enable
        logic [DATA_W-1:0] rdata;    // Read data register
        logic              out;      // Final output register
        logic              irq;      // Interrupt request register
        logic              keep;     // Keep-alive register
    } nco_state_s;

    nco_state_s r_ff;                // Current state
    nco_state_s nxt_r_ff;            // Next state

    // --------------------------------------------------------------
    // Helper functions
    // --------------------------------------------------------------
    // Pulse length minus one for a width code
    function automatic logic [PWC_W-1:0] pw_last(input logic [2:0] code);
        logic [PWC_W-1:0] len;
        len = PWC_W'(1) << code;
        pw_last = len - PWC_W'(1);
    endfunction

    // Replace one byte of a 20-bit word
    function automatic logic [ACC_W-1:0] put_byte(
        input logic [ACC_W-1:0]  word,
        input logic [1:0]        idx,
        input logic [DATA_W-1:0] data);
        logic [ACC_W-1:0] res;
        res = word;
        unique case (idx)
            2'h0: res[7:0]   = data;
            2'h1: res[15:8]  = data;
            default: res[19:16] = data[3:0];
        endcase
        put_byte = res;
    endfunction

    // Read one byte of a 20-bit word, unused bits zero
    function automatic logic [DATA_W-1:0] get_byte(
        input logic [ACC_W-1:0] word,
        input logic [1:0]       idx);
        logic [DATA_W-1:0] res;
        res = 8'h00;
        unique case (idx)
            2'h0: res = word[7:0];
            2'h1: res = word[15:8];
            default: res = {4'h0, word[19:16]};
        endcase
        get_byte = res;
    endfunction

    // --------------------------------------------------------------
    // Next-state logic
    // --------------------------------------------------------------
    logic              src;          // Selected source level
    logic              tick;         // Rising edge of source, enabled
    logic [ACC_W:0]    sum;          // Accumulator plus carry bit
    logic              carry;        // Overflow on this tick
    logic              inc_wr;       // Write to any increment byte
    logic              ints_on;      // All enables except module

    always_comb begin
        nxt_r_ff = r_ff;
        inc_wr   = 1'b0;
        ints_on  = r_ff.ie && r_ff.pe && r_ff.ge;

        // Source select, reserved code yields a flat level
        unique case (r_ff.cks)
            CKS_FAST: src = FAST_OSC;
            CKS_SYS:  src = SYS_CLK_SRC;
            CKS_CELL: src = CELL_OUT;
            default:  src = 1'b0;
        endcase
        nxt_r_ff.src_prev = src;
        tick = r_ff.en && src && !r_ff.src_prev;

        // Adder; carry out is the overflow event
        sum   = {1'b0, r_ff.acc} + {1'b0, r_ff.shadow};
        carry = tick && sum[ACC_W];

        // Accumulate on each source edge, carry dropped
        if (tick) begin
            nxt_r_ff.acc     = sum[ACC_W-1:0];
            nxt_r_ff.pf_pend = sum[ACC_W];
            if (r_ff.pfm) begin
                // Pulse mode: restart on pending overflow
                if (r_ff.pf_pend) begin
                    nxt_r_ff.raw    = 1'b1;
                    nxt_r_ff.pw_cnt = pw_last(r_ff.pws);
                end else if (r_ff.raw && r_ff.pw_cnt != '0) begin
                    nxt_r_ff.pw_cnt = r_ff.pw_cnt - PWC_W'(1);
                end else begin
                    nxt_r_ff.raw = 1'b0;
                end
            end else begin
                // Fixed duty: toggle, width field unused
                nxt_r_ff.raw = r_ff.raw ^ sum[ACC_W];
            end
            // Shadow loads on second edge after low write
            unique case (r_ff.ld)
                LD_IDLE:  nxt_r_ff.ld = LD_IDLE;
                LD_ARMED: nxt_r_ff.ld = LD_SEEN1;
                LD_SEEN1: begin
                    nxt_r_ff.shadow = r_ff.inc;
                    nxt_r_ff.ld     = LD_IDLE;
                end
                default:  nxt_r_ff.ld = LD_IDLE;
            endcase
        end

        // Register writes
        if (WR) begin
            unique case (ADDR)
                OFS_CON: begin
                    nxt_r_ff.en  = WDATA[CON_EN];
                    nxt_r_ff.pol = WDATA[CON_POL];
                    nxt_r_ff.pfm = WDATA[CON_PFM];
                    // Polarity flip is an output edge
                    if (WDATA[CON_POL] != r_ff.pol && ints_on) begin
                        nxt_r_ff.flag = 1'b1;
                    end
                end
                OFS_CLK: begin
                    nxt_r_ff.pws = WDATA[CLK_PWS +: 3];
                    nxt_r_ff.cks = WDATA[CLK_CKS +: 2];
                end
                OFS_ACCL, OFS_ACCH, OFS_ACCU: begin
                    // Byte access to accumulator
                    nxt_r_ff.acc = put_byte(r_ff.acc,
                        2'(ADDR - OFS_ACCL), WDATA);
                end
                OFS_INCL, OFS_INCH, OFS_INCU: begin
                    // Byte access to increment
                    nxt_r_ff.inc = put_byte(r_ff.inc,
                        2'(ADDR - OFS_INCL), WDATA);
                    inc_wr = 1'b1;
                    if (ADDR == OFS_INCL && r_ff.en) begin
                        nxt_r_ff.ld = LD_ARMED;
                    end
                end
                OFS_IRQ: begin
                    // Flag is written; zero clears it
                    nxt_r_ff.flag = WDATA[IRQ_FLAG];
                    nxt_r_ff.ie   = WDATA[IRQ_IE];
                    nxt_r_ff.pe   = WDATA[IRQ_PE];
                    nxt_r_ff.ge   = WDATA[IRQ_GE];
                    if (WDATA[IRQ_PE] == 1'b0) begin
                        nxt_r_ff.pe = 1'b0;
                    end
                end
                default: ;                                  // Unmapped
            endcase
        end

        // Disabled module: shadow follows the write at once
        if (inc_wr && !r_ff.en) begin
            nxt_r_ff.shadow = nxt_r_ff.inc;
            nxt_r_ff.ld     = LD_IDLE;
        end

        // Overflow sets flag, winning over a clear
        if (carry) begin
            nxt_r_ff.flag = 1'b1;
        end

        // Read data, valid only in the cycle after the strobe
        nxt_r_ff.rdata = 8'h00;
        if (RD) begin
            unique case (ADDR)
                OFS_CON: begin
                    nxt_r_ff.rdata[CON_EN]  = r_ff.en;
                    nxt_r_ff.rdata[CON_OUT] = r_ff.out;
                    nxt_r_ff.rdata[CON_POL] = r_ff.pol;
                    nxt_r_ff.rdata[CON_PFM] = r_ff.pfm;
                end
                OFS_CLK: begin
                    nxt_r_ff.rdata[CLK_PWS +: 3] = r_ff.pws;
                    nxt_r_ff.rdata[CLK_CKS +: 2] = r_ff.cks;
                end
                OFS_ACCL, OFS_ACCH, OFS_ACCU: begin
                    nxt_r_ff.rdata = get_byte(r_ff.acc,
                        2'(ADDR - OFS_ACCL));
                end
                OFS_INCL, OFS_INCH, OFS_INCU: begin
                    nxt_r_ff.rdata = get_byte(r_ff.inc,
                        2'(ADDR - OFS_INCL));
                end
                OFS_IRQ: begin
                    nxt_r_ff.rdata[IRQ_FLAG] = r_ff.flag;
                    nxt_r_ff.rdata[IRQ_IE]   = r_ff.ie;
                    nxt_r_ff.rdata[IRQ_PE]   = r_ff.pe;
                    nxt_r_ff.rdata[IRQ_GE]   = r_ff.ge;
                end
                default: nxt_r_ff.rdata = 8'h00;           // Unmapped
            endcase
        end

        // Final stage: polarity applied last
        nxt_r_ff.out  = nxt_r_ff.raw ^ nxt_r_ff.pol;
        // Request needs module and all three enables
        nxt_r_ff.irq  = nxt_r_ff.flag && nxt_r_ff.en && nxt_r_ff.ie
                        && nxt_r_ff.pe && nxt_r_ff.ge;
        // Fast oscillator kept alive while selected and on
        nxt_r_ff.keep = nxt_r_ff.en && (nxt_r_ff.cks == CKS_FAST);
    end

    // --------------------------------------------------------------
    // State register
    // --------------------------------------------------------------
    // All fields cleared, increment low bit set
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            r_ff        <= '0;
            r_ff.acc    <= ACC_RST;
            r_ff.inc    <= INC_RST;
            r_ff.shadow <= INC_RST;
            r_ff.ld     <= LD_IDLE;
        end else begin
            r_ff <= nxt_r_ff;
        end
    end

    // --------------------------------------------------------------
    // Outputs straight from the state register
    // --------------------------------------------------------------
    assign RDATA     = r_ff.rdata;
    assign NCO_OUT   = r_ff.out;
    assign IRQ       = r_ff.irq;
    assign KEEP_FAST = r_ff.keep;

endmodule

//--- verif/nco_properties.sv
/*
 * Port-level checker for the phase-accumulator oscillator.
 * Assumes it is bound to nco_top and sees only that module's ports.
 */
`timescale 1ns/1ps

module nco_properties
    import nco_pkg::*;
(
    input wire logic              REF_CLK,     // Register clock
    input wire logic              RESETN,      // Async reset, active low
    input wire logic [ADDR_W-1:0] ADDR,        // Register address
    input wire logic [DATA_W-1:0] WDATA,       // Write data
    input wire logic              WR,          // Write strobe
    input wire logic              RD,          // Read strobe
    input wire logic [DATA_W-1:0] RDATA,       // Read data
    input wire logic              FAST_OSC,    // Fast source level
    input wire logic              SYS_CLK_SRC, // System source level
    input wire logic              CELL_OUT,    // Logic cell source level
    input wire logic              NCO_OUT,     // Final output
    input wire logic              IRQ,         // Interrupt request
    input wire logic              KEEP_FAST    // Fast source keep-alive
);
    // ----------------------------------------------------------
    // Shadow of the written control fields
    // ----------------------------------------------------------
    logic       en_ff;  // Enable as last written
    logic       pol_ff; // Polarity as last written
    logic [1:0] cks_ff; // Clock select as last written
    logic [2:0] ien_ff; // Request enables as last written
    logic       gate;   // All request enables set
    logic       keep;   // Fast source must stay alive

    assign gate = en_ff & (&ien_ff);
    assign keep = en_ff & (cks_ff == CKS_FAST);

    // Follow register writes seen on the port
    always_ff @(posedge REF_CLK or negedge RESETN) begin
        if (!RESETN) begin
            en_ff  <= 1'b0;
            pol_ff <= 1'b0;
            cks_ff <= 2'h0;
            ien_ff <= 3'h0;
        end else if (WR) begin
            if (ADDR == OFS_CON) begin
                en_ff  <= WDATA[CON_EN];
                pol_ff <= WDATA[CON_POL];
            end
            if (ADDR == OFS_CLK) begin
                cks_ff <= WDATA[CLK_CKS +: 2];
            end
            if (ADDR == OFS_IRQ) begin
                ien_ff <= WDATA[IRQ_IE +: 3];
            end
        end
    end

    // ----------------------------------------------------------
    // Properties
    // ----------------------------------------------------------
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RESETN);

    // Polarity flipped while long disabled, so no edge is in flight
    sequence s_pol_write;
        WR && ADDR == OFS_CON && !WDATA[CON_EN] && WDATA[CON_POL] != pol_ff
            && !en_ff && !$past(en_ff) && !$past(en_ff, 2);
    endsequence

    // Disabled for a while and no recent register write
    sequence s_quiet_off;
        !en_ff && !$past(en_ff) && !$past(en_ff, 2) && !$past(en_ff, 3)
            && !$past(WR) && !$past(WR, 2);
    endsequence

    a_pol_flip: assert property (
        s_pol_write |-> ##2 NCO_OUT != $past(NCO_OUT, 2))
        else $error("output did not invert after polarity write");
    a_out_hold: assert property (
        s_quiet_off |-> $stable(NCO_OUT))
        else $error("output moved while disabled");
    a_con_readback: assert property (
        RD && ADDR == OFS_CON |=> RDATA[6] == 1'b0 && RDATA[3:1] == 3'h0
            && RDATA[CON_OUT] == $past(NCO_OUT))
        else $error("control read does not match output");
    a_upper_nibble: assert property (
        RD && (ADDR == OFS_ACCU || ADDR == OFS_INCU) |=> RDATA[7:4] == 4'h0)
        else $error("upper byte high nibble not zero");
    a_clk_reserved: assert property (
        RD && ADDR == OFS_CLK |=> RDATA[4:2] == 3'h0)
        else $error("clock control reserved bits not zero");
    a_unmapped_zero: assert property (
        RD && ADDR > OFS_IRQ |=> RDATA == 8'h00)
        else $error("unmapped read not zero");
    a_irq_gate: assert property (
        !gate && !$past(gate) |-> !IRQ)
        else $error("request raised without all enables");
    a_keep_on: assert property (
        keep && $past(keep) |-> KEEP_FAST)
        else $error("fast source not kept alive");
    a_keep_off: assert property (
        !keep && !$past(keep) |-> !KEEP_FAST)
        else $error("fast source kept alive needlessly");
endmodule

bind nco_top nco_properties i_nco_properties (
    .REF_CLK(REF_CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .FAST_OSC(FAST_OSC),
    .SYS_CLK_SRC(SYS_CLK_SRC), .CELL_OUT(CELL_OUT), .NCO_OUT(NCO_OUT),
    .IRQ(IRQ), .KEEP_FAST(KEEP_FAST));

//--- verif/tb_top.sv
/*
 * Self-checking bench for the phase-accumulator oscillator.
 * Assumes the checker is bound from its own file; sources are driven here.
 */
`timescale 1ns/1ps

module tb_top
    import nco_pkg::*;
;
    // ----------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------
    logic        ref_clk = 1'b0; // 10 MHz register clock
    logic        resetn  = 1'b0; // Reset, active low
    logic [3:0]  addr    = 4'h0; // Register address
    logic [7:0]  wdata   = 8'h00; // Write data
    logic        wr      = 1'b0; // Write strobe
    logic        rd      = 1'b0; // Read strobe
    logic [2:0]  src     = 3'h0; // Source levels: cell, system, fast
    logic [7:0]  rdata;          // Read data
    logic        nco_out;        // Final output
    logic        irq;            // Interrupt request
    logic        keep_fast;      // Keep-alive
    logic [19:0] acc;            // Accumulator as read back
    logic [19:0] want;           // Expected accumulator
    int          hi;             // Ticks seen active
    int          n_fail = 0;
    int          checks_done = 0;
    logic [7:0]  rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                                  8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

    // Clock, 100 ns period
    always #50 ref_clk = ~ref_clk;

    nco_top i_nco_top (
        .REF_CLK(ref_clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .FAST_OSC(src[0]),
        .SYS_CLK_SRC(src[1]), .CELL_OUT(src[2]), .NCO_OUT(nco_out),
        .IRQ(irq), .KEEP_FAST(keep_fast));

    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic chk(input string nm, input logic [19:0] e,
                       input logic [19:0] s);
        checks_done++;
        if (s !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, s);
            n_fail++;
        end
    endtask

    // One-cycle write strobe
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd_reg(a, d);
        chk($sformatf("register %0h", a), {12'h0, e}, {12'h0, d});
    endtask

    // Three bytes, upper and high first so the low byte commits
    task automatic set3(input logic [3:0] a, input logic [19:0] v);
        wr_reg(a + 4'h2, {4'h0, v[19:16]});
        wr_reg(a + 4'h1, v[15:8]);
        wr_reg(a, v[7:0]);
    endtask

    task automatic get_acc(output logic [19:0] v);
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        rd_reg(OFS_ACCL, b0);
        rd_reg(OFS_ACCH, b1);
        rd_reg(OFS_ACCU, b2);
        v = {b2[3:0], b1, b0};
    endtask

    // One rising edge on the chosen sources, then let it settle
    task automatic pulse(input logic [2:0] m);
        @(posedge ref_clk);
        src <= m;
        repeat (2) @(posedge ref_clk);
        src <= 3'h0;
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        // Reset values, one unmapped place included
        foreach (rst_tab[i]) rchk(4'(i), rst_tab[i]);
        wr_reg(OFS_ACCU, 8'hff);
        rchk(OFS_ACCU, 8'h0f);
        wr_reg(OFS_INCU, 8'hff);
        rchk(OFS_INCU, 8'h0f);
        wr_reg(OFS_CLK, 8'hff);
        rchk(OFS_CLK, 8'he3);
        wr_reg(4'hf, 8'hff);
        rchk(4'hf, 8'h00);
        // Polarity, read-only output bit and request gating
        wr_reg(OFS_IRQ, 8'h0e);
        wr_reg(OFS_CON, 8'h7f);
        rchk(OFS_CON, 8'h31);
        chk("inverted output", 20'h1, {19'h0, nco_out});
        rchk(OFS_IRQ, 8'h0f);
        chk("request disabled", 20'h0, {19'h0, irq});
        wr_reg(OFS_CON, 8'h91);
        pulse(3'h0);
        chk("request", 20'h1, {19'h0, irq});
        wr_reg(OFS_IRQ, 8'h0e);
        pulse(3'h0);
        chk("request cleared", 20'h0, {19'h0, irq});
        wr_reg(OFS_CON, 8'h00);
        wr_reg(OFS_IRQ, 8'h00);
        // Fixed duty: widest pulse select must have no effect
        set3(OFS_INCL, 20'h40000);
        set3(OFS_ACCL, 20'h00000);
        wr_reg(OFS_CLK, 8'he1);
        wr_reg(OFS_CON, 8'h80);
        repeat (6) pulse(3'b010);
        chk("duty output", 20'h1, {19'h0, nco_out});
        get_acc(acc);
        chk("accumulator", 20'h80000, acc);
        rchk(OFS_IRQ, 8'h01);
        repeat (2) pulse(3'b010);
        chk("duty output", 20'h0, {19'h0, nco_out});
        get_acc(acc);
        chk("accumulator", 20'h00000, acc);
        // Enabled change: second edge loads, and still adds the old value
        set3(OFS_INCL, 20'h00001);
        repeat (3) pulse(3'b010);
        get_acc(acc);
        chk("accumulator", 20'h80001, acc);
        rchk(OFS_INCL, 8'h01);
        // Each select code against all three sources
        want = acc;
        for (int c = 0; c < 4; c++) begin
            wr_reg(OFS_CLK, 8'(c));
            pulse(3'b001);
            pulse(3'b010);
            pulse(3'b100);
            want += (c < 3) ? 20'h1 : 20'h0;
            get_acc(acc);
            chk("selected source", want, acc);
            chk("keep alive", 20'(c == 0), 20'(keep_fast));
        end
        // Pulse widths of one to eight source periods
        for (int p = 0; p < 4; p++) begin
            wr_reg(OFS_CON, 8'h00);
            set3(OFS_ACCL, 20'hfffff);
            wr_reg(OFS_CLK, {3'(p), 5'h01});
            wr_reg(OFS_CON, 8'h81);
            pulse(3'b010);
            hi = 0;
            repeat (10) begin
                pulse(3'b010);
                hi += int'(nco_out === 1'b1);
            end
            chk("pulse width", 20'(1 << p), 20'(hi));
        end
        // Width longer than the overflow period holds the output active
        wr_reg(OFS_CON, 8'h00);
        set3(OFS_INCL, 20'h80000);
        set3(OFS_ACCL, 20'h00000);
        wr_reg(OFS_CON, 8'h81);
        repeat (3) pulse(3'b010);
        hi = 0;
        repeat (8) begin
            pulse(3'b010);
            hi += int'(nco_out === 1'b1);
        end
        chk("held active", 20'h8, 20'(hi));
        summarize();
    end

    // Guard against a hang
    initial begin
        repeat (60000) @(posedge ref_clk);
        n_fail++;
        summarize();
    end
endmodule
